// File: design/pidc_core.sv
// pidc_core: discrete pid controller, recomputed once per scan period.
// assumes all inputs come from logic on mclk_in; no pin synchronisers needed.
`timescale 1ns/1ps

// Summary of operation
// - enable low clears state, output zero
// - each term counts only when enabled
// - recompute per scan period, zero means always
// - time inputs unsigned, 100 ms per count
// - gain is percent, divided by hundred
// - setpoint and actual are signed 16-bit
// - clamp algorithm output to unipolar or bipolar range
// - unipolar negative result outputs zero
// - output sums enabled term contributions
// - proportional is gain times control difference
// - integral adds gain*period/reset*difference each scan
// - derivative uses previous minus current actual
// - manual override passes manual value through
// - override release resumes algorithm, no bumpless
// - limit flag when result leaves range, low during manual override
module pidc_core
	import pidc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = PIDC_TICK_CYCLES
) (
	input  wire logic                          mclk_in,
	input  wire logic                          sys_rst_in,
	input  wire logic                          controller_enable_in,
	input  wire logic                          prop_term_enable_in,
	input  wire logic                          integ_term_enable_in,
	input  wire logic                          deriv_term_enable_in,
	input  wire logic                          hand_override_in,
	input  wire logic                          unipolar_range_in,
	input  wire logic signed [PIDC_VAL_W-1:0]  setpoint_in,
	input  wire logic signed [PIDC_VAL_W-1:0]  actual_in,
	input  wire logic [PIDC_PARAM_W-1:0]       gain_in,
	input  wire logic [PIDC_PARAM_W-1:0]       reset_time_in,
	input  wire logic [PIDC_PARAM_W-1:0]       rate_time_in,
	input  wire logic [PIDC_PARAM_W-1:0]       scan_period_in,
	input  wire logic signed [PIDC_OUT_W-1:0]  manual_value_in,
	output logic signed [PIDC_OUT_W-1:0]       manip_out,
	output logic                               range_limit_flag_out
);

	// ----------------------------------------------------------------
	// input carriers
	// ----------------------------------------------------------------
	pidc_terms_t  terms;
	pidc_params_t prm;

	assign terms = '{prop: prop_term_enable_in, integ: integ_term_enable_in, deriv: deriv_term_enable_in};
	assign prm   = '{gain: gain_in, reset_time: reset_time_in, rate_time: rate_time_in,
	                 scan_period: scan_period_in};

	// ----------------------------------------------------------------
	// scan timing
	// ----------------------------------------------------------------
	localparam logic [PIDC_TICK_W-1:0] TICK_LAST = PIDC_TICK_W'(TICK_CYCLES - 1);

	logic [PIDC_TICK_W-1:0]  tick_cnt;
	logic [PIDC_PARAM_W-1:0] period_cnt;
	wire                     tick_done;
	wire                     period_zero;
	wire                     period_done;
	wire                     scan_now;
	wire [PIDC_TICK_W-1:0]   next_tick_cnt;
	wire [PIDC_PARAM_W-1:0]  next_period_cnt;

	assign tick_done       = (tick_cnt == TICK_LAST);
	assign period_zero     = (prm.scan_period == PIDC_PARAM_ZERO);
	assign period_done     = tick_done && (period_cnt >= prm.scan_period - 16'h0001);
	assign scan_now        = controller_enable_in && (period_zero || period_done);
	assign next_tick_cnt   = (!controller_enable_in || tick_done || period_zero) ? PIDC_TICK_ZERO
	                         : tick_cnt + 23'h000001;
	assign next_period_cnt = (!controller_enable_in || period_zero || period_done) ? PIDC_PARAM_ZERO
	                         : (tick_done ? period_cnt + 16'h0001 : period_cnt);

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			tick_cnt   <= PIDC_TICK_ZERO;
			period_cnt <= PIDC_PARAM_ZERO;
		end else begin
			tick_cnt   <= next_tick_cnt;
			period_cnt <= next_period_cnt;
		end
	end

	// ----------------------------------------------------------------
	// arithmetic
	// ----------------------------------------------------------------
	logic signed [PIDC_INTEG_W-1:0] integ;
	logic signed [PIDC_VAL_W-1:0]   prev_actual;
	logic signed [PIDC_OUT_W-1:0]   algo_hold;
	logic                           limit_hold;

	wire signed [PIDC_MATH_W-1:0] gain_w;
	wire signed [PIDC_MATH_W-1:0] tn_w;
	wire signed [PIDC_MATH_W-1:0] tv_w;
	wire signed [PIDC_MATH_W-1:0] tc_w;
	wire signed [PIDC_MATH_W-1:0] diff_w;
	wire signed [PIDC_MATH_W-1:0] dact_w;
	wire signed [PIDC_MATH_W-1:0] prop_val;
	wire signed [PIDC_MATH_W-1:0] integ_inc;
	wire signed [PIDC_MATH_W-1:0] integ_sum;
	wire signed [PIDC_MATH_W-1:0] integ_sat;
	wire signed [PIDC_MATH_W-1:0] deriv_val;
	wire signed [PIDC_MATH_W-1:0] deriv_den;
	wire signed [PIDC_MATH_W-1:0] total;
	wire signed [PIDC_MATH_W-1:0] out_lo_w;
	wire signed [PIDC_MATH_W-1:0] out_hi_w;
	wire signed [PIDC_OUT_W-1:0]  out_lo;
	wire signed [PIDC_OUT_W-1:0]  clamped;
	wire                          over_hi;
	wire                          under_lo;

	// zero-extended unsigned parameters, sign-extended signed values
	assign gain_w = $signed({36'h000000000, prm.gain});
	assign tn_w   = $signed({36'h000000000, prm.reset_time});
	assign tv_w   = $signed({36'h000000000, prm.rate_time});
	assign tc_w   = $signed({36'h000000000, prm.scan_period});
	assign diff_w = PIDC_MATH_W'(setpoint_in) - PIDC_MATH_W'(actual_in);
	assign dact_w = PIDC_MATH_W'(prev_actual) - PIDC_MATH_W'(actual_in);

	// signed division truncates toward zero
	assign prop_val  = (gain_w * diff_w) / PIDC_PCT_DIV;
	assign integ_inc = (tn_w == PIDC_ZERO) ? PIDC_ZERO
	                   : (gain_w * tc_w * diff_w) / (tn_w * PIDC_PCT_DIV);
	assign integ_sum = PIDC_MATH_W'(integ) + integ_inc;
	assign integ_sat = (integ_sum > PIDC_INTEG_MAX) ? PIDC_INTEG_MAX
	                   : ((integ_sum < PIDC_INTEG_MIN) ? PIDC_INTEG_MIN : integ_sum);
	// zero period runs every cycle; divisor taken as one count
	assign deriv_den = ((tc_w == PIDC_ZERO) ? PIDC_ONE : tc_w) * PIDC_PCT_DIV;
	assign deriv_val = (gain_w * tv_w * dact_w) / deriv_den;

	assign total = (terms.prop  ? prop_val  : PIDC_ZERO)
	             + (terms.integ ? integ_sat : PIDC_ZERO)
	             + (terms.deriv ? deriv_val : PIDC_ZERO);

	assign out_lo   = unipolar_range_in ? PIDC_UNP_MIN : PIDC_BIP_MIN;
	assign out_lo_w = PIDC_MATH_W'(out_lo);
	assign out_hi_w = PIDC_MATH_W'(PIDC_OUT_MAX);
	assign over_hi  = (total > out_hi_w);
	assign under_lo = (total < out_lo_w);
	assign clamped  = over_hi ? PIDC_OUT_MAX : (under_lo ? out_lo : total[PIDC_OUT_W-1:0]);

	// ----------------------------------------------------------------
	// history and held algorithm result
	// ----------------------------------------------------------------
	wire signed [PIDC_INTEG_W-1:0] next_integ;
	wire signed [PIDC_VAL_W-1:0]   next_prev_actual;
	wire signed [PIDC_OUT_W-1:0]   next_algo_hold;
	wire                           next_limit_hold;

	assign next_integ       = !controller_enable_in ? '0
	                          : ((scan_now && terms.integ) ? integ_sat[PIDC_INTEG_W-1:0] : integ);
	assign next_prev_actual = !controller_enable_in ? '0 : (scan_now ? actual_in : prev_actual);
	assign next_algo_hold   = !controller_enable_in ? '0 : (scan_now ? clamped : algo_hold);
	assign next_limit_hold  = controller_enable_in && (scan_now ? (over_hi || under_lo) : limit_hold);

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			integ       <= '0;
			prev_actual <= '0;
			algo_hold   <= '0;
			limit_hold  <= 1'b0;
		end else begin
			integ       <= next_integ;
			prev_actual <= next_prev_actual;
			algo_hold   <= next_algo_hold;
			limit_hold  <= next_limit_hold;
		end
	end

	// ----------------------------------------------------------------
	// output stage
	// ----------------------------------------------------------------
	wire signed [PIDC_OUT_W-1:0] algo_pick;
	wire signed [PIDC_OUT_W-1:0] algo_out;
	wire signed [PIDC_OUT_W-1:0] next_manip;
	wire                         next_limit_flag;

	assign algo_pick       = scan_now ? clamped : algo_hold;
	// a held bipolar result may be negative when unipolar is chosen between scans
	assign algo_out        = (unipolar_range_in && algo_pick[PIDC_OUT_W-1]) ? PIDC_UNP_MIN : algo_pick;
	assign next_manip      = !controller_enable_in ? '0
	                         : (hand_override_in ? manual_value_in : algo_out);
	assign next_limit_flag = controller_enable_in && !hand_override_in
	                         && (scan_now ? (over_hi || under_lo) : limit_hold);

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			manip_out            <= '0;
			range_limit_flag_out <= 1'b0;
		end else begin
			manip_out            <= next_manip;
			range_limit_flag_out <= next_limit_flag;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (sys_rst_in);

	disabled_output_zero_a: assert property (
		!controller_enable_in |=> (manip_out == '0) && (integ == '0) && (prev_actual == '0)
		&& !range_limit_flag_out)
		else $error("disabled controller did not clear output and history");

	manual_pass_a: assert property (
		controller_enable_in && hand_override_in |=> manip_out == $past(manual_value_in))
		else $error("manual value not passed to output");

	unipolar_nonneg_a: assert property (
		controller_enable_in && !hand_override_in && unipolar_range_in |=> !manip_out[PIDC_OUT_W-1])
		else $error("negative output in unipolar mode");

	limit_at_bound_a: assert property (
		range_limit_flag_out |-> (manip_out == PIDC_OUT_MAX) || (manip_out == PIDC_BIP_MIN)
		|| (manip_out == PIDC_UNP_MIN))
		else $error("limit flag without output at a range bound");

	zero_period_scan_a: assert property (
		controller_enable_in && (scan_period_in == PIDC_PARAM_ZERO) |-> scan_now)
		else $error("zero scan period did not recompute every cycle");

	actual_latch_a: assert property (
		scan_now ##1 controller_enable_in |-> prev_actual == $past(actual_in))
		else $error("actual value not latched at scan");

	integ_hold_a: assert property (
		controller_enable_in && !integ_term_enable_in |=> integ == $past(integ))
		else $error("integral changed while its term is off");

	prop_only_a: assert property (
		scan_now && prop_term_enable_in && !integ_term_enable_in && !deriv_term_enable_in
		&& !hand_override_in && !unipolar_range_in && (gain_in == 16'h0064)
		&& (diff_w < 52'sh0000000000FFF) && (diff_w > -52'sh0000000001000)
		|=> manip_out == $past(diff_w[PIDC_OUT_W-1:0]))
		else $error("proportional output differs from control difference at unit gain");

	// ----------------------------------------------------------------
	// scan timing checks
	// ----------------------------------------------------------------
	scan_restart_a: assert property (
		scan_now |=> (tick_cnt == PIDC_TICK_ZERO) && (period_cnt == PIDC_PARAM_ZERO))
		else $error("timers not restarted after a scan");

	tick_step_a: assert property (
		controller_enable_in && !period_zero && !tick_done |=> tick_cnt == $past(tick_cnt) + 23'h000001)
		else $error("tick counter did not advance by one");

	enable_restart_a: assert property (
		!controller_enable_in |=> (tick_cnt == PIDC_TICK_ZERO) && (period_cnt == PIDC_PARAM_ZERO)
		&& (algo_hold == '0))
		else $error("disabled controller kept timers or held result");

	hold_between_a: assert property (
		controller_enable_in && !scan_now && !hand_override_in && !unipolar_range_in
		|=> manip_out == $past(algo_hold))
		else $error("output changed between scans");

	integ_scan_only_a: assert property (
		controller_enable_in && !scan_now |=> integ == $past(integ))
		else $error("integral changed outside a scan");

	// ----------------------------------------------------------------
	// term and output checks
	// ----------------------------------------------------------------
	zero_reset_hold_a: assert property (
		scan_now && (reset_time_in == PIDC_PARAM_ZERO) |=> integ == $past(integ))
		else $error("integral moved with zero reset time");

	hand_flag_low_a: assert property (
		hand_override_in |=> !range_limit_flag_out)
		else $error("limit flag raised during manual override");

	no_terms_zero_a: assert property (
		scan_now && !prop_term_enable_in && !integ_term_enable_in && !deriv_term_enable_in
		&& !hand_override_in |=> (manip_out == '0) && !range_limit_flag_out)
		else $error("output nonzero with all terms off");

	deriv_steady_a: assert property (
		scan_now && deriv_term_enable_in && !prop_term_enable_in && !integ_term_enable_in
		&& !hand_override_in && (actual_in == prev_actual) |=> manip_out == '0)
		else $error("derivative output without a change of actual value");

	zero_gain_a: assert property (
		scan_now && !hand_override_in && (gain_in == PIDC_PARAM_ZERO) && !integ_term_enable_in
		|=> manip_out == '0)
		else $error("output nonzero at zero gain");

	resume_algo_a: assert property (
		scan_now && !hand_override_in |=> manip_out == $past(clamped))
		else $error("algorithm result not driven without override");

	scan_flag_a: assert property (
		scan_now && !hand_override_in |=> range_limit_flag_out == $past(over_hi || under_lo))
		else $error("limit flag does not follow the scan result");

endmodule

// File: design/pidc_pkg.sv
// pidc_pkg: constants and carrier types for the discrete pid controller.
// assumes a single 50 MHz clock and a synchronous active-high reset.
package pidc_pkg;

	// ----------------------------------------------------------------
	// clock and time base
	// ----------------------------------------------------------------
	localparam int unsigned PIDC_CLK_PERIOD_NS = 20;
	localparam int unsigned PIDC_TICK_MS       = 100;
	localparam int unsigned PIDC_TICK_CYCLES   = (PIDC_TICK_MS * 1000000) / PIDC_CLK_PERIOD_NS;
	localparam int unsigned PIDC_TICK_W        = 23;

	// ----------------------------------------------------------------
	// operand widths
	// ----------------------------------------------------------------
	localparam int unsigned PIDC_PARAM_W = 16;
	localparam int unsigned PIDC_VAL_W   = 16;
	localparam int unsigned PIDC_OUT_W   = 13;
	localparam int unsigned PIDC_MATH_W  = 52;
	localparam int unsigned PIDC_INTEG_W = 32;

	// ----------------------------------------------------------------
	// arithmetic constants
	// ----------------------------------------------------------------
	localparam logic signed [PIDC_MATH_W-1:0]  PIDC_PCT_DIV   = 52'sh0000000000064;
	localparam logic signed [PIDC_MATH_W-1:0]  PIDC_ONE       = 52'sh0000000000001;
	localparam logic signed [PIDC_MATH_W-1:0]  PIDC_ZERO      = 52'sh0000000000000;
	localparam logic signed [PIDC_MATH_W-1:0]  PIDC_INTEG_MAX = 52'sh000007FFFFFFF;
	localparam logic signed [PIDC_MATH_W-1:0]  PIDC_INTEG_MIN = -52'sh0000080000000;
	localparam logic signed [PIDC_OUT_W-1:0]   PIDC_OUT_MAX   = 13'sh0FFF;
	localparam logic signed [PIDC_OUT_W-1:0]   PIDC_BIP_MIN   = -13'sh1000;
	localparam logic signed [PIDC_OUT_W-1:0]   PIDC_UNP_MIN   = 13'sh0000;
	localparam logic [PIDC_PARAM_W-1:0]        PIDC_PARAM_ZERO = 16'h0000;
	localparam logic [PIDC_TICK_W-1:0]         PIDC_TICK_ZERO  = 23'h000000;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic prop;
		logic integ;
		logic deriv;
	} pidc_terms_t;

	typedef struct packed {
		logic [PIDC_PARAM_W-1:0] gain;
		logic [PIDC_PARAM_W-1:0] reset_time;
		logic [PIDC_PARAM_W-1:0] rate_time;
		logic [PIDC_PARAM_W-1:0] scan_period;
	} pidc_params_t;

endpackage

// File: verification/pidc_prog_model.sv
// pidc_prog_model: the user program side, presenting coils and operands to the controller.
// assumes the bench updates its requests just after the falling clock edge.
`timescale 1ns/1ps
module pidc_prog_model
	import pidc_pkg::*;
(
	input  wire logic                          enable_req_in,
	input  wire logic                          hand_req_in,
	input  wire logic                          unipolar_req_in,
	input  wire pidc_terms_t                   terms_req_in,
	input  wire pidc_params_t                  params_req_in,
	input  wire logic signed [PIDC_VAL_W-1:0]  setpoint_req_in,
	input  wire logic signed [PIDC_VAL_W-1:0]  actual_req_in,
	input  wire logic signed [PIDC_OUT_W-1:0]  manual_req_in,
	output logic                               enable_out,
	output logic                               hand_out,
	output logic                               unipolar_out,
	output pidc_terms_t                        terms_out,
	output pidc_params_t                       params_out,
	output logic signed [PIDC_VAL_W-1:0]       setpoint_out,
	output logic signed [PIDC_VAL_W-1:0]       actual_out,
	output logic signed [PIDC_OUT_W-1:0]       manual_out
);
	// ----------------------------------------------------------------
	// operand presentation
	// ----------------------------------------------------------------
	assign enable_out   = enable_req_in;
	assign hand_out     = hand_req_in;
	assign unipolar_out = unipolar_req_in;
	assign terms_out    = terms_req_in;
	assign params_out   = params_req_in;
	assign setpoint_out = setpoint_req_in;
	assign actual_out   = actual_req_in;
	// 13-bit signed operand cannot leave the bipolar range
	assign manual_out   = manual_req_in;
endmodule

// File: verification/pidc_core_tb_top.sv
// pidc_core_tb_top: self-checking bench for pidc_core with a short tick.
// assumes pidc_pkg compiled first; operands come through pidc_prog_model.
`timescale 1ns/1ps
module pidc_core_tb_top;
	import pidc_pkg::*;
	logic               mclk_in    = 1'b0;
	logic               sys_rst_in = 1'b1;
	logic               en = 1'b0, hand = 1'b0, unip = 1'b0, nh;
	pidc_terms_t        terms = '0;
	pidc_params_t       prm = '0;
	logic signed [15:0] sp = '0, act = '0;
	logic signed [12:0] man = '0, manip, exp_out = '0, v0;
	logic               flag, exp_flag = 1'b0;
	wire logic          w_en, w_hand, w_unip;
	pidc_terms_t        w_terms;
	pidc_params_t       w_prm;
	wire logic [15:0]   w_sp, w_act;
	wire logic [12:0]   w_man;
	int                 fail_count = 0;
	int                 comparisons = 0;
	int unsigned        seed = 58273;
	int unsigned        r;
	longint             prev = 0;

	pidc_prog_model pidc_prog_model_inst (.enable_req_in(en), .hand_req_in(hand), .unipolar_req_in(unip),
		.terms_req_in(terms), .params_req_in(prm), .setpoint_req_in(sp), .actual_req_in(act),
		.manual_req_in(man), .enable_out(w_en), .hand_out(w_hand), .unipolar_out(w_unip), .terms_out(w_terms),
		.params_out(w_prm), .setpoint_out(w_sp), .actual_out(w_act), .manual_out(w_man));
	pidc_core #(.TICK_CYCLES(4)) pidc_core_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.controller_enable_in(w_en), .prop_term_enable_in(w_terms.prop), .integ_term_enable_in(w_terms.integ),
		.deriv_term_enable_in(w_terms.deriv), .hand_override_in(w_hand), .unipolar_range_in(w_unip),
		.setpoint_in(w_sp), .actual_in(w_act), .gain_in(w_prm.gain), .reset_time_in(w_prm.reset_time),
		.rate_time_in(w_prm.rate_time), .scan_period_in(w_prm.scan_period), .manual_value_in(w_man),
		.manip_out(manip), .range_limit_flag_out(flag));

	initial begin
		forever #10 mclk_in = ~mclk_in;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] expv);
		comparisons++;
		if (seen !== expv) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask

	// expectation for one scan per clock (scan period zero)
	task automatic predict();
		longint e, s, d, lo;
		if (!en) begin
			prev = 0;
			exp_out = '0;
			exp_flag = 1'b0;
		end else if (hand) begin
			exp_out = man;
			exp_flag = 1'b0;
			prev = act;
		end else begin
			e = longint'(sp) - longint'(act);
			d = longint'(prm.gain) * longint'(prm.rate_time) * (prev - longint'(act)) / 100;
			prev = act;
			s = (terms.prop ? longint'(prm.gain) * e / 100 : 0) + (terms.deriv ? d : 0);
			lo = unip ? 0 : -4096;
			exp_flag = s > 4095 || s < lo;
			exp_out = s > 4095 ? 13'h0FFF : (s < lo ? 13'(lo) : 13'(s));
		end
	endtask

	task automatic step_check();
		predict();
		@(negedge mclk_in);
		check(manip, exp_out);
		check(flag, exp_flag);
	endtask

	task automatic wrap_up();
		if (fail_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge mclk_in);
		fail_count++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(negedge mclk_in);
		sys_rst_in = 1'b0;
		check(manip, 16'h0000);
		check(flag, 16'h0000);
		// integral over periodic scans, five counts per scan
		en = 1'b1;
		terms = 3'b010;
		prm = {16'h0064, 16'h0001, 16'h0000, 16'h0001};
		sp = 16'h0005;
		repeat (12) @(negedge mclk_in);
		v0 = manip;
		repeat (40) @(negedge mclk_in);
		check(manip, 16'(v0) + 16'h0032);
		prm.reset_time = 16'h0000;
		@(negedge mclk_in);
		v0 = manip;
		repeat (40) @(negedge mclk_in);
		check(manip, 16'(v0));
		terms = 3'b000;
		repeat (8) @(negedge mclk_in);
		check(manip, 16'h0000);
		terms = 3'b010;
		repeat (8) @(negedge mclk_in);
		check(manip, 16'(v0));
		en = 1'b0;
		prm = '0;
		step_check();
		// corner cases at scan period zero
		en = 1'b1;
		terms = 3'b100;
		prm.gain = 16'h0064;
		sp = 16'h000A;
		act = 16'h0003;
		step_check();
		prm.gain = 16'hFFFF;
		sp = 16'h7FFF;
		act = 16'h8000;
		step_check();
		unip = 1'b1;
		sp = 16'hFFFB;
		act = 16'h0000;
		step_check();
		terms = 3'b001;
		prm = {16'h0064, 16'h0000, 16'h0003, 16'h0000};
		act = 16'hFFF9;
		step_check();
		step_check();
		terms = 3'b101;
		prm.gain = 16'h0000;
		step_check();
		// held negative result reads zero once unipolar is chosen
		unip = 1'b0;
		terms = 3'b100;
		prm = {16'h0064, 16'h0000, 16'h0000, 16'h0002};
		sp = 16'h0000;
		act = 16'h0005;
		repeat (10) @(negedge mclk_in);
		check(manip, 16'hFFFB);
		unip = 1'b1;
		@(negedge mclk_in);
		check(manip, 16'h0000);
		prev = act;
		// random operands, override released straight to the algorithm or through a disable
		for (int k = 0; k < 600; k++) begin
			r = rnd();
			nh = r[5:4] == 2'b00;
			en = r[3:0] != 4'h0 || nh;
			hand = nh;
			unip = r[8];
			terms = r[11:9];
			sp = r[12] ? 16'(rnd()) : 16'(rnd() % 64);
			act = r[13] ? 16'(rnd()) : 16'(rnd() % 64);
			prm = {16'(rnd() % 400), 16'h0000, 16'(rnd() % 4), 16'h0000};
			man = 13'(rnd());
			step_check();
		end
		wrap_up();
	end
endmodule
